// ---- logic/fcw_pkg.sv ----
// Purpose: Shared constants and types for the code-write command block
// Assumes: AXI4-Lite register access, 32-bit data, one clock
// Notes:   Read command codes and status values are local choices
package fcw_pkg;
  // Command codes
  localparam logic [7:0] CMD_SINGLE_WRITE   = 8'h1f;
  localparam logic [7:0] CMD_BUFFERED_WRITE = 8'h24;
  localparam logic [7:0] CMD_SINGLE_READ    = 8'h60;
  localparam logic [7:0] CMD_BUFFERED_READ  = 8'h61;
  // Code length and code type values
  localparam logic [3:0]  FIX_LEN_FAM1   = 4'h5;
  localparam logic [3:0]  FIX_LEN_FAM2   = 4'h7;
  localparam logic [15:0] TYPE_PERMANENT = 16'h3032;
  localparam logic [15:0] TYPE_OVERWRITE = 16'h3131;
  localparam logic [15:0] TYPE_FAM2      = 16'h3532;
  localparam logic [15:0] TAG_TYPE_50    = 16'h3530;
  localparam logic [15:0] TAG_TYPE_02    = 16'h3032;
  localparam logic [15:0] TAG_TYPE_11    = 16'h3131;
  localparam logic [3:0]  COMPAT_BYTES   = 4'h8;
  localparam int          FAM2_HEX_CHARS = 3;
  localparam int          MAX_CHARS      = 7;
  // Character ranges
  localparam logic [7:0] CHR_0 = 8'h30;
  localparam logic [7:0] CHR_9 = 8'h39;
  localparam logic [7:0] CHR_A = 8'h41;
  localparam logic [7:0] CHR_F = 8'h46;
  // Response status values
  localparam logic [7:0] ST_OK    = 8'h00;
  localparam logic [7:0] ST_FAIL  = 8'h03;
  localparam logic [7:0] ST_PARAM = 8'h04;
  // Register byte offsets
  localparam logic [7:0] ADDR_CMD      = 8'h00;
  localparam logic [7:0] ADDR_DATA_LO  = 8'h04;
  localparam logic [7:0] ADDR_DATA_HI  = 8'h08;
  localparam logic [7:0] ADDR_CTRL     = 8'h0c;
  localparam logic [7:0] ADDR_TAG_TYPE = 8'h10;
  localparam logic [7:0] ADDR_RESP     = 8'h14;
  localparam logic [7:0] ADDR_RD_CODE  = 8'h18;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h1c;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h20;
  // Field positions
  localparam int CTRL_GO    = 0;
  localparam int CTRL_ABORT = 1;
  localparam int IRQ_RESP   = 0;
  localparam int IRQ_ERR    = 1;
  localparam int IRQ_BITS   = 2;
  localparam logic [1:0] AXI_OKAY   = 2'b00;
  localparam logic [1:0] AXI_DECERR = 2'b11;

  typedef enum logic [2:0] {
    FCW_IDLE, FCW_WRITE, FCW_WAIT, FCW_LEAVE, FCW_ENTER, FCW_READ, FCW_RWAIT
  } fcw_state_t;

  // Request handed to the radio head
  typedef struct packed {
    logic [55:0] chars;
    logic [3:0]  bytes;
    logic        lock;
    logic        family2;
  } fcw_head_req_t;

  // Response telegram bytes 0 to 3
  typedef struct packed {
    logic [7:0] count;
    logic [7:0] status;
    logic [7:0] ctl;
    logic [7:0] code;
  } fcw_resp_t;
endpackage

// ---- logic/fcw_fix_check.sv ----
// Purpose: Checks code length and code type of a write telegram; characters and tag type for the second family only
// Assumes: Characters packed low byte first, first character at bit 0
// Notes:   Purely combinational
`timescale 1ns/1ps
module fcw_fix_check
  import fcw_pkg::*;
(
  input  wire logic [3:0]  fix_len,
  input  wire logic [15:0] fix_type,
  input  wire logic [55:0] chars,
  input  wire logic [15:0] tag_type,
  output logic             valid,
  output logic             family2,
  output logic             lock
);
  function automatic logic in_range(input logic [7:0] c,
                                    input logic [7:0] lo,
                                    input logic [7:0] hi);
    return (c >= lo) && (c <= hi);
  endfunction

  logic fam1_ok;
  logic fam2_ok;
  logic chars_ok;

  always_comb begin
    chars_ok = 1'b1;
    for (int i = 0; i < MAX_CHARS; i++) begin
      if (i < FAM2_HEX_CHARS) begin
        chars_ok = chars_ok & (in_range(chars[i*8 +: 8], CHR_0, CHR_9) |
                               in_range(chars[i*8 +: 8], CHR_A, CHR_F));
      end else begin
        chars_ok = chars_ok & in_range(chars[i*8 +: 8], CHR_0, CHR_9);
      end
    end
    fam1_ok = (fix_len == FIX_LEN_FAM1) &&
              ((fix_type == TYPE_PERMANENT) || (fix_type == TYPE_OVERWRITE));
    fam2_ok = (fix_len == FIX_LEN_FAM2) && (fix_type == TYPE_FAM2) &&
              chars_ok && (tag_type == TAG_TYPE_50);
    valid   = fam1_ok | fam2_ok;
    family2 = fam2_ok;
    lock    = fam1_ok && (fix_type == TYPE_PERMANENT);
  end
endmodule

// ---- logic/fcw_core.sv ----
// Purpose: Code-write command interpreter with AXI4-Lite registers
// Assumes: Radio head logic runs on aclk; head_done is a one-cycle pulse
// Notes:   Operation
// Operation
// - Single write command 1Fh makes one write attempt, then answers.
// - Buffered write command 24h retries until success, answers each success.
// - After buffered success, wait for a new tag, then restart the command.
// - Bytes 2-3 hold code type high first; data runs to length plus 3.
// - First family: length 5; type '02' permanent, '11' overwritable.
// - Second family: length 7, type '52', code stays overwritable.
// - Second-family compatibility code occupies the tag's first 8 bytes.
// - Code read with tag type '50' returns the tag's 4-byte code.
// - Code read with tag type '02' or '11' reads first-family code.
//
// Decided for this implementation: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module fcw_core
  import fcw_pkg::*;
#(
  parameter int ADDR_W = 8
)(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic                   head_wr_req,
  output logic                   head_rd_req,
  output fcw_head_req_t          head_req,
  input  wire logic              head_done,
  input  wire logic              head_ok,
  input  wire logic [31:0]       head_code,
  input  wire logic              tag_present,
  output logic                   irq
);
  if (ADDR_W < 8) begin : g_chk
    $error("ADDR_W must be at least 8");
  end

  typedef struct packed {
    fcw_state_t         st;
    logic [31:0]        cmd;
    logic [63:0]        data;
    logic [15:0]        tag_type;
    fcw_resp_t          resp;
    logic [31:0]        rd_code;
    logic [IRQ_BITS-1:0] irq_stat;
    logic [IRQ_BITS-1:0] irq_mask;
    logic               irq;
    logic               resp_pulse;
    logic               wr_req;
    logic               rd_req;
    fcw_head_req_t      hreq;
    logic [ADDR_W-1:0]  awaddr;
    logic               aw_held;
    logic [31:0]        wdata;
    logic [3:0]         wstrb;
    logic               w_held;
    logic               awready;
    logic               wready;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               arready;
    logic               rvalid;
    logic [31:0]        rdata;
    logic [1:0]         rresp;
  } fcw_regs_t;

  fcw_regs_t q;
  fcw_regs_t next_q;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0]        off);
    return a[7:2] == off[7:2];
  endfunction

  logic [7:0]  cmd_code;
  logic [3:0]  fix_len;
  logic [15:0] fix_type;
  logic        chk_valid;
  logic        chk_fam2;
  logic        chk_lock;
  logic        is_single;
  logic        is_buffered;
  logic        is_read;
  logic        read_type_ok;

  assign cmd_code = q.cmd[7:0];
  assign fix_len  = q.cmd[15:12];
  assign fix_type = {q.cmd[23:16], q.cmd[31:24]};
  assign is_single   = cmd_code == CMD_SINGLE_WRITE;
  assign is_buffered = cmd_code == CMD_BUFFERED_WRITE;
  assign is_read     = (cmd_code == CMD_SINGLE_READ) ||
                       (cmd_code == CMD_BUFFERED_READ);
  assign read_type_ok = (q.tag_type == TAG_TYPE_50) ||
                        (q.tag_type == TAG_TYPE_02) ||
                        (q.tag_type == TAG_TYPE_11);

  fcw_fix_check u_check (
    .fix_len  (fix_len),
    .fix_type (fix_type),
    .chars    (q.data[55:0]),
    .tag_type (q.tag_type),
    .valid    (chk_valid),
    .family2  (chk_fam2),
    .lock     (chk_lock)
  );

  logic                go;
  logic                abort;
  logic [IRQ_BITS-1:0] irq_set;
  logic [IRQ_BITS-1:0] irq_clr;
  logic [31:0]         wv;

  always_comb begin
    next_q     = q;
    go         = 1'b0;
    abort      = 1'b0;
    irq_set    = '0;
    irq_clr    = '0;
    wv         = '0;
    next_q.wr_req     = 1'b0;
    next_q.rd_req     = 1'b0;
    next_q.resp_pulse = 1'b0;

    // Write address and data are taken in either order
    if (s_axi_awvalid && q.awready) begin
      next_q.awaddr  = s_axi_awaddr;
      next_q.aw_held = 1'b1;
    end
    if (s_axi_wvalid && q.wready) begin
      next_q.wdata  = s_axi_wdata;
      next_q.wstrb  = s_axi_wstrb;
      next_q.w_held = 1'b1;
    end
    if (q.bvalid && s_axi_bready) begin
      next_q.bvalid = 1'b0;
    end
    if (q.aw_held && q.w_held && !q.bvalid) begin
      next_q.aw_held = 1'b0;
      next_q.w_held  = 1'b0;
      next_q.bvalid  = 1'b1;
      next_q.bresp   = AXI_OKAY;
      wv = merge(32'h0000_0000, q.wdata, q.wstrb);
      if (hit(q.awaddr, ADDR_CMD)) begin
        next_q.cmd = merge(q.cmd, q.wdata, q.wstrb);
      end else if (hit(q.awaddr, ADDR_DATA_LO)) begin
        next_q.data[31:0] = merge(q.data[31:0], q.wdata, q.wstrb);
      end else if (hit(q.awaddr, ADDR_DATA_HI)) begin
        next_q.data[63:32] = merge(q.data[63:32], q.wdata, q.wstrb);
      end else if (hit(q.awaddr, ADDR_CTRL)) begin
        go    = wv[CTRL_GO];
        abort = wv[CTRL_ABORT];
      end else if (hit(q.awaddr, ADDR_TAG_TYPE)) begin
        next_q.tag_type = wv[15:0];
      end else if (hit(q.awaddr, ADDR_IRQ_STAT)) begin
        irq_clr = wv[IRQ_BITS-1:0];
      end else if (hit(q.awaddr, ADDR_IRQ_MASK)) begin
        next_q.irq_mask = wv[IRQ_BITS-1:0];
      end else if (!hit(q.awaddr, ADDR_RESP) &&
                   !hit(q.awaddr, ADDR_RD_CODE)) begin
        next_q.bresp = AXI_DECERR;
      end
    end

    // Command sequencer
    case (q.st)
      FCW_IDLE: begin
        if (go && (is_single || is_buffered)) begin
          if (chk_valid) begin
            next_q.hreq.chars   = q.data[55:0];
            next_q.hreq.lock    = chk_lock;
            next_q.hreq.family2 = chk_fam2;
            next_q.hreq.bytes   = chk_fam2 ? COMPAT_BYTES : fix_len;
            next_q.st           = FCW_WRITE;
          end else begin
            next_q.resp.status = ST_PARAM;
            next_q.resp_pulse  = 1'b1;
            irq_set[IRQ_ERR]   = 1'b1;
          end
        end else if (go && is_read) begin
          if (read_type_ok) begin
            next_q.st = FCW_READ;
          end else begin
            next_q.resp.status = ST_PARAM;
            next_q.resp_pulse  = 1'b1;
            irq_set[IRQ_ERR]   = 1'b1;
          end
        end else if (go) begin
          next_q.resp.status = ST_PARAM;
          next_q.resp_pulse  = 1'b1;
          irq_set[IRQ_ERR]   = 1'b1;
        end
      end
      FCW_WRITE: begin
        next_q.wr_req = 1'b1;
        next_q.st     = FCW_WAIT;
      end
      FCW_WAIT: begin
        if (head_done && head_ok) begin
          next_q.resp.status = ST_OK;
          next_q.resp_pulse  = 1'b1;
          irq_set[IRQ_RESP]  = 1'b1;
          next_q.st = is_buffered ? FCW_LEAVE : FCW_IDLE;
        end else if (head_done && is_buffered) begin
          next_q.st = FCW_WRITE;
        end else if (head_done) begin
          next_q.resp.status = ST_FAIL;
          next_q.resp_pulse  = 1'b1;
          irq_set[IRQ_ERR]   = 1'b1;
          next_q.st          = FCW_IDLE;
        end
      end
      FCW_LEAVE: begin
        if (!tag_present) begin
          next_q.st = FCW_ENTER;
        end
      end
      FCW_ENTER: begin
        if (tag_present) begin
          next_q.st = FCW_WRITE;
        end
      end
      FCW_READ: begin
        next_q.rd_req = 1'b1;
        next_q.st     = FCW_RWAIT;
      end
      FCW_RWAIT: begin
        if (head_done) begin
          next_q.rd_code     = head_ok ? head_code : 32'h0000_0000;
          next_q.resp.status = head_ok ? ST_OK : ST_FAIL;
          next_q.resp_pulse  = 1'b1;
          irq_set[IRQ_RESP]  = 1'b1;
          next_q.st          = FCW_IDLE;
        end
      end
      default: begin
        next_q.st = FCW_IDLE;
      end
    endcase
    if (abort && (q.st != FCW_WRITE) && (q.st != FCW_READ)) begin
      next_q.st = FCW_IDLE;
    end
    if (next_q.resp_pulse) begin
      next_q.resp.code  = cmd_code;
      next_q.resp.ctl   = q.cmd[15:8];
      next_q.resp.count = q.resp.count + 8'h01;
    end

    // Set wins over a clear in the same cycle
    next_q.irq_stat = (q.irq_stat & ~irq_clr) | irq_set;
    next_q.irq      = |(next_q.irq_stat & next_q.irq_mask);

    // Read channel
    if (q.rvalid && s_axi_rready) begin
      next_q.rvalid = 1'b0;
    end
    if (s_axi_arvalid && q.arready) begin
      next_q.rvalid = 1'b1;
      next_q.rresp  = AXI_OKAY;
      next_q.rdata  = 32'h0000_0000;
      if (hit(s_axi_araddr, ADDR_CMD)) begin
        next_q.rdata = q.cmd;
      end else if (hit(s_axi_araddr, ADDR_DATA_LO)) begin
        next_q.rdata = q.data[31:0];
      end else if (hit(s_axi_araddr, ADDR_DATA_HI)) begin
        next_q.rdata = q.data[63:32];
      end else if (hit(s_axi_araddr, ADDR_CTRL)) begin
        next_q.rdata[2:0] = q.st;
      end else if (hit(s_axi_araddr, ADDR_TAG_TYPE)) begin
        next_q.rdata[15:0] = q.tag_type;
      end else if (hit(s_axi_araddr, ADDR_RESP)) begin
        next_q.rdata = q.resp;
      end else if (hit(s_axi_araddr, ADDR_RD_CODE)) begin
        next_q.rdata = q.rd_code;
      end else if (hit(s_axi_araddr, ADDR_IRQ_STAT)) begin
        next_q.rdata[IRQ_BITS-1:0] = q.irq_stat;
      end else if (hit(s_axi_araddr, ADDR_IRQ_MASK)) begin
        next_q.rdata[IRQ_BITS-1:0] = q.irq_mask;
      end else begin
        next_q.rresp = AXI_DECERR;
      end
    end
    next_q.awready = !next_q.aw_held && !next_q.bvalid;
    next_q.wready  = !next_q.w_held && !next_q.bvalid;
    next_q.arready = !next_q.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q          <= '0;
      q.st       <= FCW_IDLE;
      q.awready  <= 1'b1;
      q.wready   <= 1'b1;
      q.arready  <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  assign s_axi_awready = q.awready;
  assign s_axi_wready  = q.wready;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rdata   = q.rdata;
  assign s_axi_rresp   = q.rresp;
  assign head_wr_req   = q.wr_req;
  assign head_rd_req   = q.rd_req;
  assign head_req      = q.hreq;
  assign irq           = q.irq;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_single_once: assert property (
    q.st == FCW_WAIT && is_single && head_done && !head_ok
    |=> q.st == FCW_IDLE ##1 !q.wr_req)
    else $error("single write retried");
  chk_buffered_retry: assert property (
    q.st == FCW_WAIT && is_buffered && head_done && !head_ok && !abort
    |=> q.st == FCW_WRITE ##1 q.wr_req)
    else $error("buffered write not retried");
  chk_new_tag_wait: assert property (
    q.st == FCW_LEAVE && tag_present && !abort |=> q.st == FCW_LEAVE)
    else $error("restart without tag change");
  chk_perm_type: assert property (
    q.wr_req && q.hreq.lock |-> !q.hreq.family2 &&
    fix_type == TYPE_PERMANENT && fix_len == FIX_LEN_FAM1)
    else $error("permanent lock with wrong type");
  chk_fam2_type: assert property (
    q.wr_req && q.hreq.family2 |-> !q.hreq.lock &&
    fix_type == TYPE_FAM2 && fix_len == FIX_LEN_FAM2)
    else $error("second family type mismatch");
  chk_fam2_bytes: assert property (
    q.wr_req && q.hreq.family2 |-> q.hreq.bytes == COMPAT_BYTES)
    else $error("compatibility code size wrong");
  chk_read_code: assert property (
    q.st == FCW_RWAIT && head_done && head_ok
    |=> q.rd_code == $past(head_code) && q.resp.status == ST_OK)
    else $error("read code not returned");
  chk_read_type: assert property (
    $rose(q.rd_req) |-> $past(read_type_ok, 2))
    else $error("read with unselected tag type");
  chk_resp_echo: assert property (
    q.resp_pulse |-> q.resp.code == cmd_code &&
    q.resp.ctl == q.cmd[15:8] &&
    q.resp.count == $past(q.resp.count) + 8'h01)
    else $error("response fields wrong");
  chk_irq_level: assert property (
    q.irq == |($past(next_q.irq_stat) & $past(next_q.irq_mask)))
    else $error("interrupt level wrong");

  cov_single_ok: cover property (
    q.st == FCW_WAIT && is_single && head_done && head_ok);
  cov_buffered_cycle: cover property (
    q.st == FCW_ENTER && tag_present ##1 q.st == FCW_WRITE);
  cov_param_err: cover property (q.resp_pulse && q.resp.status == ST_PARAM);
  cov_read_done: cover property (q.st == FCW_RWAIT && head_done);
endmodule

// ---- tb/fcw_head_model.sv ----
// Purpose: Behavioural radio head and tag for the code-write block
// Assumes: One head request at a time, answer after lat idle cycles
// Notes:   Fails the first fails write attempts after clr
`timescale 1ns/1ps
module fcw_head_model
  import fcw_pkg::*;
(
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic          head_wr_req,
  input  wire logic          head_rd_req,
  input  wire fcw_head_req_t head_req,
  input  wire logic          clr,
  input  wire logic [3:0]    fails,
  input  wire logic [3:0]    lat,
  input  wire logic [31:0]   tag_code,
  output logic               head_done,
  output logic               head_ok,
  output logic [31:0]        head_code,
  output logic [7:0]         n_req,
  output fcw_head_req_t      seen
);
  logic       busy;
  logic       rd;
  logic [3:0] cnt;

  always_ff @(posedge aclk) begin
    head_done <= 1'b0;
    head_ok   <= ~head_ok;
    head_code <= ~head_code;
    if (!aresetn) begin
      busy      <= 1'b0;
      n_req     <= 8'h0;
      head_ok   <= 1'b0;
      head_code <= 32'h0;
    end else if (clr) begin
      n_req <= 8'h0;
    end else if (head_wr_req || head_rd_req) begin
      busy  <= 1'b1;
      cnt   <= lat;
      rd    <= head_rd_req;
      seen  <= head_req;
      n_req <= n_req + 8'h1;
    end else if (busy && cnt == 4'h0) begin
      busy      <= 1'b0;
      head_done <= 1'b1;
      head_ok   <= rd || (n_req > {4'h0, fails});
      head_code <= rd ? tag_code : ~head_code;
    end else if (busy) begin
      cnt <= cnt - 4'h1;
    end
  end
endmodule

// ---- tb/tb_fixcode_write_commands.sv ----
// Purpose: Self-checking bench for the code-write command block
// Assumes: Registers reached over AXI4-Lite, head model on far side
// Notes:   Reset and decode-error checks, table rows, then retry, wait, abort and mask cases
`timescale 1ns/1ps
module tb_fixcode_write_commands
  import fcw_pkg::*;
;
  typedef struct packed {
    logic [31:0] cw, lo, hi;
    logic [15:0] tt;
    logic [7:0]  st;
    logic [3:0]  nb;
    logic        lk, f2, rd;
  } fcw_row_t;
  localparam logic [31:0] TCODE = 32'h5a3c96e1;
  localparam logic [31:0] CW1   = 32'h3230521f;
  localparam logic [31:0] CWB   = 32'h32305224;
  localparam logic [31:0] LO1   = 32'h34333231;
  localparam logic [31:0] LO2   = 32'h30394631;
  localparam logic [31:0] HI2   = 32'h00393231;
  localparam logic [31:0] CW2   = 32'h3235721f;
  fcw_row_t rows [11] = '{
    '{CW1, LO1, 32'h35, TAG_TYPE_02, ST_OK, 4'h5, 1'b1, 1'b0, 1'b0},
    '{32'h3131531f, LO1, 32'h35, TAG_TYPE_11, ST_OK, 4'h5, 1'b0, 1'b0,
      1'b0},
    '{CW2, LO2, HI2, TAG_TYPE_50, ST_OK, 4'h8, 1'b0, 1'b1, 1'b0},
    '{CW2, 32'h30394147, HI2, TAG_TYPE_50, ST_PARAM, 4'h0, 1'b0, 1'b0,
      1'b0},
    '{CW2, 32'h41394131, HI2, TAG_TYPE_50, ST_PARAM, 4'h0, 1'b0, 1'b0,
      1'b0},
    '{CW2, LO2, 32'h003a3231, TAG_TYPE_50, ST_PARAM, 4'h0, 1'b0, 1'b0,
      1'b0},
    '{32'h3230621f, LO1, 32'h35, TAG_TYPE_02, ST_PARAM, 4'h0, 1'b0, 1'b0,
      1'b0},
    '{CW2, LO2, HI2, TAG_TYPE_02, ST_PARAM, 4'h0, 1'b0, 1'b0, 1'b0},
    '{32'h33335224, LO1, 32'h35, TAG_TYPE_02, ST_PARAM, 4'h0, 1'b0, 1'b0,
      1'b0},
    '{32'h00000160, 32'h0, 32'h0, TAG_TYPE_50, ST_OK, 4'h0, 1'b0, 1'b0,
      1'b1},
    '{32'h00000161, 32'h0, 32'h0, TAG_TYPE_11, ST_OK, 4'h0, 1'b0, 1'b0,
      1'b1}
  };
  logic          aclk, aresetn, tag_present, irq, clr;
  logic [7:0]    awaddr, araddr, n_req, rc;
  logic [31:0]   wdata, rdata, hcode, v;
  logic [3:0]    wstrb, fails, lat;
  logic [1:0]    bresp, rresp;
  logic          awvalid, awready, wvalid, wready, bvalid, bready;
  logic          arvalid, arready, rvalid, rready;
  logic          wr_req, rd_req, done, ok;
  fcw_head_req_t hreq, seen;
  int            n_fail, checked, cyc;

  fcw_core fcw_core_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .head_wr_req(wr_req),
    .head_rd_req(rd_req), .head_req(hreq), .head_done(done),
    .head_ok(ok), .head_code(hcode), .tag_present(tag_present), .irq(irq));
  fcw_head_model fcw_head_model_i (.aclk(aclk), .aresetn(aresetn),
    .head_wr_req(wr_req), .head_rd_req(rd_req), .head_req(hreq),
    .clr(clr), .fails(fails), .lat(lat), .tag_code(TCODE),
    .head_done(done), .head_ok(ok), .head_code(hcode), .n_req(n_req),
    .seen(seen));

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  task conclude;
    $display("Comparisons %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      conclude;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        input logic [1:0] er);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    d = rdata;
    chk({30'h0, rresp}, {30'h0, er});
  endtask

  task automatic resp(input logic [31:0] cw, input logic [7:0] st);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 400) begin
      @(posedge aclk);
      n++;
    end
    chk({31'h0, irq}, 32'h1);
    axi_rd(ADDR_RESP, v, AXI_OKAY);
    rc = rc + 8'h1;
    chk(v, {rc, st, cw[15:8], cw[7:0]});
    axi_wr(ADDR_IRQ_STAT, 32'h3, AXI_OKAY);
  endtask

  task automatic run(input logic [31:0] cw, input logic [31:0] lo,
                     input logic [31:0] hi, input logic [15:0] tt,
                     input logic [7:0] st);
    @(posedge aclk);
    clr <= 1'b1;
    @(posedge aclk);
    clr <= 1'b0;
    axi_wr(ADDR_TAG_TYPE, {16'h0, tt}, AXI_OKAY);
    axi_wr(ADDR_DATA_LO, lo, AXI_OKAY);
    axi_wr(ADDR_DATA_HI, hi, AXI_OKAY);
    axi_wr(ADDR_CMD, cw, AXI_OKAY);
    axi_wr(ADDR_CTRL, 32'h1, AXI_OKAY);
    resp(cw, st);
  endtask

  initial begin
    {awaddr, araddr, wdata, awvalid, wvalid, bready} = '0;
    {arvalid, rready, clr, fails, lat, rc, n_fail, checked, cyc} = '0;
    wstrb       = 4'hf;
    tag_present = 1'b1;
    aresetn     = 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    chk({31'h0, irq}, 32'h0);
    axi_rd(ADDR_RESP, v, AXI_OKAY);
    chk(v, 32'h0);
    axi_rd(8'h40, v, AXI_DECERR);
    chk(v, 32'h0);
    axi_wr(8'h40, 32'hffffffff, AXI_DECERR);
    axi_wr(ADDR_IRQ_MASK, 32'h3, AXI_OKAY);
    for (int i = 0; i < 11; i++) begin
      fails <= 4'h0;
      lat   <= i[3:0];
      run(rows[i].cw, rows[i].lo, rows[i].hi, rows[i].tt, rows[i].st);
      chk({24'h0, n_req}, {31'h0, rows[i].st == ST_OK});
      if (rows[i].rd) begin
        axi_rd(ADDR_RD_CODE, v, AXI_OKAY);
        chk(v, TCODE);
      end else if (rows[i].st == ST_OK) begin
        chk(seen.chars[31:0], rows[i].lo);
        chk({2'b00, seen.bytes, seen.lock, seen.family2, seen.chars[55:32]},
            {2'b00, rows[i].nb, rows[i].lk, rows[i].f2,
             rows[i].hi[23:0]});
      end
    end
    fails <= 4'h1;
    run(CW1, LO1, 32'h35, TAG_TYPE_02, ST_FAIL);
    chk({24'h0, n_req}, 32'h1);
    fails <= 4'h2;
    run(CWB, LO1, 32'h35, TAG_TYPE_02, ST_OK);
    chk({24'h0, n_req}, 32'h3);
    repeat (20) @(posedge aclk);
    chk({24'h0, n_req}, 32'h3);
    tag_present <= 1'b0;
    repeat (4) @(posedge aclk);
    tag_present <= 1'b1;
    resp(CWB, ST_OK);
    chk({24'h0, n_req}, 32'h4);
    axi_wr(ADDR_CTRL, 32'h2, AXI_OKAY);
    axi_rd(ADDR_CTRL, v, AXI_OKAY);
    chk({29'h0, v[2:0]}, 32'h0);
    axi_wr(ADDR_IRQ_MASK, 32'h0, AXI_OKAY);
    fails <= 4'h0;
    axi_wr(ADDR_CMD, CW1, AXI_OKAY);
    axi_wr(ADDR_CTRL, 32'h1, AXI_OKAY);
    repeat (30) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    axi_rd(ADDR_IRQ_STAT, v, AXI_OKAY);
    chk(v, 32'h1);
    axi_wr(ADDR_IRQ_MASK, 32'h1, AXI_OKAY);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h1);
    axi_wr(ADDR_IRQ_STAT, 32'h1, AXI_OKAY);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    conclude;
  end
endmodule
